/* pkg/sse_defs.svh */
// Constants for the serial shift and storage expander.
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// ****************************************************************
// Widths and reset values
// ****************************************************************
// Number of shift stages and storage bits.
`define SSE_WIDTH 8
// Value a shift stage takes when cleared.
`define SSE_STAGE_CLEAR 1'h0
// Value of each storage bit after reset.
`define SSE_STORE_RESET 1'h0
// Parallel outputs float after reset until the enable is seen low.
`define SSE_OE_N_RESET 1'h1
// Reset value of the storage clock, shift flag and clear synchroniser flops.
`define SSE_SYNC_RESET 2'h0

`endif

/* pkg/sse_pkg.sv */
// Types shared by the serial shift and storage expander.
package sse_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Two-flop synchroniser chain; bit 0 is the metastable first stage.
  typedef logic [1:0] sse_sync_type;

endpackage

/* hw/sse_expander.sv */
// Serial-in shift register feeding a storage register with 3-state outputs.
//
// Functional notes
// - Eight-stage shift register feeds eight-bit storage register.
// - Storage register drives eight floatable parallel outputs.
// - Shift and storage registers have independent clocks.
// - Clear resets shift register at once, beats clock.
// - Serial input in, last stage on cascade output.
// - Enable high floats parallel outputs; cascade stays driven.
// - Both registers act only on rising clock edges.
// - Tied clocks: storage captures pre-edge shift contents.
// - Tied clocks: eight pulses fill, ninth shows data.
// - Each shift edge: stage zero takes input, others shift.
// - Clear held low forces every shift stage zero.
// - Storage edge copies shift contents; otherwise storage holds.

`include "sse_defs.svh"

module sse_expander
  import sse_pkg::*;
#(
  parameter int WIDTH = `SSE_WIDTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic shift_clock_in,
  input wire logic shift_data_in,
  input wire logic shift_clear_n_in,
  input wire logic storage_clock_in,
  input wire logic output_enable_n_in,
  output logic [WIDTH-1:0] parallel_out,
  output logic parallel_oe_n_out,
  output logic cascade_out
);

  // ****************************************************************
  // Link domain: the shift register on the host's shift clock
  // ****************************************************************
  logic link_clear;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] shift_feed;
  logic shift_toggle_reg;
  logic fresh_reg;

  // The clear acts without any clock, so it is an asynchronous reset of
  // the link flops; the system reset joins it because the shift clock may
  // stand still and could never apply a synchronous one.
  // A clear that ends close to a shift edge may or may not let that edge
  // act; the host must keep the release well away from it.
  assign link_clear = rst_in | ~shift_clear_n_in;

  // Stage zero takes the serial input, every later stage its neighbour.
  assign shift_feed = {shift_reg[WIDTH-2:0], shift_data_in};

  // One flop per stage, rising edge only, clear first.
  for (genvar i = 0; i < WIDTH; i++) begin : g_stage
    always_ff @(posedge shift_clock_in or posedge link_clear) begin
      if (link_clear) begin
        shift_reg[i] <= `SSE_STAGE_CLEAR;
      end else begin
        shift_reg[i] <= shift_feed[i];
      end
    end
  end

  // Each shift edge flips this flag so the reference domain learns that
  // the word moved; the word itself stays put for a whole shift period.
  always_ff @(posedge shift_clock_in or posedge link_clear) begin
    if (link_clear) begin
      shift_toggle_reg <= 1'h0;
    end else begin
      shift_toggle_reg <= ~shift_toggle_reg;
    end
  end

  // The last stage is the cascade output; it never floats.
  assign cascade_out = shift_reg[WIDTH-1];

  // Helper for the checks: high when no clear came since the last edge.
  always_ff @(posedge shift_clock_in or posedge link_clear) begin
    if (link_clear) begin
      fresh_reg <= 1'h0;
    end else begin
      fresh_reg <= 1'h1;
    end
  end

  // ****************************************************************
  // Reference domain: synchronisers
  // ****************************************************************
  sse_sync_type store_clk_sync_reg;
  sse_sync_type toggle_sync_reg;
  sse_sync_type clear_sync_reg;
  sse_sync_type oe_sync_reg;
  logic store_clk_last_reg;
  logic toggle_last_reg;
  logic store_edge;
  logic shift_moved;
  logic clear_active;

  // The storage clock, clear and enable pins and the link flag pass two flops before logic sees them.
  // The clear is synchronised only for the mirror; the shift stages see
  // the raw pin, since the clear must act without waiting for a clock.
  // Storage clock and shift flag use equal depth, so on tied clocks both
  // events land in the same cycle and the storage takes the old word.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      store_clk_sync_reg <= `SSE_SYNC_RESET;
      toggle_sync_reg <= `SSE_SYNC_RESET;
      clear_sync_reg <= `SSE_SYNC_RESET;
      // The enable pin idles high, so its chain resets high as well; a
      // low reset value would drive the outputs for two cycles.
      oe_sync_reg <= {2{`SSE_OE_N_RESET}};
    end else begin
      store_clk_sync_reg <= {store_clk_sync_reg[0], storage_clock_in};
      toggle_sync_reg <= {toggle_sync_reg[0], shift_toggle_reg};
      clear_sync_reg <= {clear_sync_reg[0], ~shift_clear_n_in};
      oe_sync_reg <= {oe_sync_reg[0], output_enable_n_in};
    end
  end

  // Delayed copies for edge and change detection.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      store_clk_last_reg <= 1'h0;
      toggle_last_reg <= 1'h0;
    end else begin
      store_clk_last_reg <= store_clk_sync_reg[1];
      toggle_last_reg <= toggle_sync_reg[1];
    end
  end

  // Only a low-to-high storage clock counts; high, low and falling hold.
  assign store_edge = store_clk_sync_reg[1] & ~store_clk_last_reg;
  assign shift_moved = toggle_sync_reg[1] ^ toggle_last_reg;
  assign clear_active = clear_sync_reg[1];

  // ****************************************************************
  // Reference domain: shift mirror, storage and output enable
  // ****************************************************************
  logic [WIDTH-1:0] mirror_reg;
  logic [WIDTH-1:0] storage_reg;
  logic oe_n_reg;

  // The mirror follows the shift register. The word is read only after
  // its flag has crossed, when it has been stable for two cycles; this
  // needs each shift clock period to last at least four reference cycles.
  // A faster host would let the word change while it is being copied, so
  // the limit is a real one for anyone driving the link harder.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mirror_reg <= {WIDTH{`SSE_STAGE_CLEAR}};
    end else if (clear_active) begin
      mirror_reg <= {WIDTH{`SSE_STAGE_CLEAR}};
    end else if (shift_moved) begin
      mirror_reg <= shift_reg;
    end
  end

  // Storage copies the mirror on its own edge and holds otherwise; a
  // clear alone never reaches it. Storage resets to zero so the outputs
  // are defined even before the host has loaded a first word.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      storage_reg <= {WIDTH{`SSE_STORE_RESET}};
    end else if (store_edge) begin
      storage_reg <= mirror_reg;
    end
  end

  // Output enable follows the synchronised pin.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      oe_n_reg <= `SSE_OE_N_RESET;
    end else begin
      oe_n_reg <= oe_sync_reg[1];
    end
  end

  // Data always carries the storage value; the enable decides the float.
  // The tri-state buffer sits outside this block, so the enable is a
  // plain registered output rather than a driven float.
  assign parallel_out = storage_reg;
  assign parallel_oe_n_out = oe_n_reg;

  // ****************************************************************
  // Checks in the link domain
  // ****************************************************************
  property p_shift_step;
    @(posedge shift_clock_in) disable iff (link_clear)
    fresh_reg |-> shift_reg ==
      {$past(shift_reg[WIDTH-2:0]), $past(shift_data_in)};
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("Shift register did not advance by one stage.");

  property p_cascade;
    @(posedge shift_clock_in) disable iff (link_clear)
    fresh_reg |-> cascade_out == $past(shift_reg[WIDTH-2]);
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("Cascade output is not the previous last-but-one stage.");

  // After a clear, only stage zero can be set by the first shift edge.
  property p_clear_release;
    @(posedge shift_clock_in) disable iff (link_clear)
    !fresh_reg |=> shift_reg[WIDTH-1:1] == '0;
  endproperty
  a_clear_release: assert property (p_clear_release)
    else $error("Stale data survived a clear of the shift register.");

  // ****************************************************************
  // Checks in the reference domain
  // ****************************************************************
  property p_clear_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    !shift_clear_n_in |-> (shift_reg == '0) && (cascade_out == 1'b0);
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("Shift register not zero while clear is held.");

  property p_mirror_clear;
    @(posedge ref_clk_in) disable iff (rst_in)
    clear_active |=> mirror_reg == '0;
  endproperty
  a_mirror_clear: assert property (p_mirror_clear)
    else $error("Mirror kept data after a clear was seen.");

  property p_store_copy;
    @(posedge ref_clk_in) disable iff (rst_in)
    store_edge |=> storage_reg == $past(mirror_reg);
  endproperty
  a_store_copy: assert property (p_store_copy)
    else $error("Storage did not take the shift contents on its edge.");

  property p_store_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !store_edge |=> $stable(storage_reg);
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("Storage changed without a storage clock edge.");

  sequence s_both_edges;
    store_edge && shift_moved && !clear_active;
  endsequence

  sequence s_lagged;
    (storage_reg == $past(mirror_reg)) && (mirror_reg == $past(shift_reg));
  endsequence

  property p_tied_lag;
    @(posedge ref_clk_in) disable iff (rst_in)
    s_both_edges |=> s_lagged;
  endproperty
  a_tied_lag: assert property (p_tied_lag)
    else $error("Storage did not lag the shift register by one pulse.");

  property p_float;
    @(posedge ref_clk_in) disable iff (rst_in)
    oe_sync_reg[1] |=> parallel_oe_n_out ##1 (parallel_oe_n_out ||
      !$past(oe_sync_reg[1]));
  endproperty
  a_float: assert property (p_float)
    else $error("Parallel outputs driven while enable is high.");

  property p_drive;
    @(posedge ref_clk_in) disable iff (rst_in)
    !oe_sync_reg[1] |=> !parallel_oe_n_out;
  endproperty
  a_drive: assert property (p_drive)
    else $error("Parallel outputs floated while enable is low.");

  property p_clear_keeps_store;
    @(posedge ref_clk_in) disable iff (rst_in)
    ($rose(clear_active) && !store_edge) |=> $stable(storage_reg);
  endproperty
  a_clear_keeps_store: assert property (p_clear_keeps_store)
    else $error("A clear disturbed the storage register.");

  // The outputs must still be floated at the first edge after a reset.
  property p_reset_float;
    @(posedge ref_clk_in)
    $fell(rst_in) |=> parallel_oe_n_out && (parallel_out == '0);
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("Parallel outputs driven straight after reset.");

  // A crossed shift edge loads the word that the link register holds.
  property p_mirror_track;
    @(posedge ref_clk_in) disable iff (rst_in)
    (shift_moved && !clear_active) |=> mirror_reg == $past(shift_reg);
  endproperty
  a_mirror_track: assert property (p_mirror_track)
    else $error("Mirror missed the word of a shift edge.");

  // A shift clock seen at one level on two edges cannot have risen in
  // between, as its phases outlast a reference period, so the word holds.
  property p_shift_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
    ($stable(shift_clock_in) && shift_clear_n_in && $past(shift_clear_n_in))
      |-> $stable(shift_reg);
  endproperty
  a_shift_quiet: assert property (p_shift_quiet)
    else $error("Shift register moved without a shift clock edge.");

endmodule

/* verif/sse_host_model.sv */
// Host model that drives the expander's serial, clock and control pins.
module sse_host_model (
  input wire logic ref_clk_in,
  output logic shift_clock_out,
  output logic shift_data_out,
  output logic shift_clear_n_out,
  output logic storage_clock_out,
  output logic output_enable_n_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic rclk_reg;
  logic tied_reg;

  // Tied mode routes one pulse train to both clock pins.
  assign storage_clock_out = tied_reg ? shift_clock_out : rclk_reg;

  // Pins start idle: clocks low, clear released, outputs floated.
  initial begin
    shift_clock_out = 1'b0;
    shift_data_out = 1'b0;
    shift_clear_n_out = 1'b1;
    output_enable_n_out = 1'b1;
    rclk_reg = 1'b0;
    tied_reg = 1'b0;
  end

  // Sends bits MSB first; the link clock rests low outside frames.
  // The 3 ns offset keeps link edges off the system clock's rising edges.
  task automatic shift_bits(input logic [7:0] bits, input int count);
    @(posedge ref_clk_in);
    #3;
    for (int i = 7; i > 7 - count; i--) begin
      shift_data_out = bits[i];
      #32 shift_clock_out = 1'b1;
      #32 shift_clock_out = 1'b0;
    end
    // Released data is not left at its last value.
    shift_data_out = ~shift_data_out;
  endtask

  // One storage pulse, each phase well over two system cycles.
  task automatic store();
    @(negedge ref_clk_in);
    rclk_reg = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    rclk_reg = 1'b0;
    repeat (3) @(negedge ref_clk_in);
  endtask

  // Level controls change at the system clock's falling edge.
  task automatic set_pins(input logic clr_n, input logic oe_n,
                          input logic tied);
    @(negedge ref_clk_in);
    shift_clear_n_out = clr_n;
    output_enable_n_out = oe_n;
    tied_reg = tied;
  endtask
endmodule

/* verif/sse_expander_test.sv */
// Self-checking bench for the serial shift and storage expander.
module sse_expander_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sclk;
  logic sdata;
  logic clr_n;
  logic rclk;
  logic oe_n;
  logic [7:0] par;
  logic par_oe_n;
  logic cascade;
  wire [7:0] pins;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  // The clock toggles every half period of 5 ns.
  always #5 ref_clk_in = ~ref_clk_in;

  // The board sees floating pins while the enable output is high.
  assign pins = par_oe_n ? 8'hzz : par;

  sse_host_model host (.ref_clk_in(ref_clk_in), .shift_clock_out(sclk),
    .shift_data_out(sdata), .shift_clear_n_out(clr_n),
    .storage_clock_out(rclk), .output_enable_n_out(oe_n));

  sse_expander #(.WIDTH(8)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .shift_clock_in(sclk), .shift_data_in(sdata),
    .shift_clear_n_in(clr_n), .storage_clock_in(rclk),
    .output_enable_n_in(oe_n), .parallel_out(par),
    .parallel_oe_n_out(par_oe_n), .cascade_out(cascade));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_enable();
    host.set_pins(1'b1, 1'b0, 1'b0);
    repeat (4) @(negedge ref_clk_in);
    chk("pins driven", pins, 8'h00);
    host.set_pins(1'b1, 1'b1, 1'b0);
    repeat (4) @(negedge ref_clk_in);
    chk("pins floated", pins, 8'hzz);
    chk("cascade kept", {7'h00, cascade}, 8'h00);
    host.set_pins(1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_shift_store();
    host.shift_bits(8'ha5, 8);
    chk("cascade after a5", {7'h00, cascade}, 8'h01);
    chk("held before store", par, 8'h00);
    host.store();
    chk("stored a5", pins, 8'ha5);
    host.shift_bits(8'h3c, 4);
    chk("cascade mid byte", {7'h00, cascade}, 8'h00);
    host.shift_bits(8'hc0, 4);
    chk("storage holds", par, 8'ha5);
    host.store();
    chk("stored 3c", pins, 8'h3c);
  endtask

  task automatic t_clear();
    host.shift_bits(8'hff, 8);
    chk("cascade ones", {7'h00, cascade}, 8'h01);
    host.set_pins(1'b0, 1'b0, 1'b0);
    #1;
    chk("cleared at once", {7'h00, cascade}, 8'h00);
    host.shift_bits(8'hff, 2);
    repeat (6) @(negedge ref_clk_in);
    chk("clear beats clock", {7'h00, cascade}, 8'h00);
    chk("storage untouched", par, 8'h3c);
    host.set_pins(1'b1, 1'b0, 1'b0);
    host.store();
    chk("stored clear", par, 8'h00);
  endtask

  task automatic t_tied();
    host.set_pins(1'b1, 1'b0, 1'b1);
    host.shift_bits(8'h96, 8);
    repeat (6) @(negedge ref_clk_in);
    chk("tied lags one", par, 8'h4b);
    host.shift_bits(8'h00, 1);
    repeat (6) @(negedge ref_clk_in);
    chk("ninth pulse", pins, 8'h96);
    host.set_pins(1'b1, 1'b0, 1'b0);
  endtask

  // Reset for ten cycles, then run each scenario once.
  initial begin
    repeat (10) @(negedge ref_clk_in);
    rst_in = 1'b0;
    @(negedge ref_clk_in);
    chk("reset outputs", par, 8'h00);
    chk("reset enable", {7'h00, par_oe_n}, 8'h01);
    chk("reset cascade", {7'h00, cascade}, 8'h00);
    repeat (3) @(negedge ref_clk_in);
    t_enable();
    t_shift_store();
    t_clear();
    t_tied();
    end_of_test();
  end
endmodule
